/* File: logic/ccd_addr_stack.sv */
`timescale 1ns/1ps
module ccd_addr_stack
   import ccd_pkg::*;
#(
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   ccd_core_if.stk  bus
);
   localparam int SP_W = $clog2(DEPTH);

   // depth must be a power of two: the pointer simply wraps
   typedef struct packed {
      logic [SP_W-1:0]             sp;
      logic [DEPTH-1:0][PA_W-1:0]  ent;
   } ccd_stk_t;

   ccd_stk_t st;
   ccd_stk_t next_st;

   always_comb begin
      next_st = st;
      if (bus.stkPush) begin
         next_st.sp = st.sp - 1'b1;
         next_st.ent[next_st.sp] = bus.stkWdata;
      end else if (bus.stkPop) begin
         next_st.sp = st.sp + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bus.stkTop = st.ent[st.sp];
   assign bus.stkPtr = st.sp;
endmodule

/* File: logic/ccd_control_top.sv */
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module ccd_control_top
   import ccd_pkg::*;
#(
   parameter int PC_W      = 11,
   parameter int STK_DEPTH = 8
) (
   input  wire logic            clk,
   input  wire logic            nrst,
   input  wire logic [IW-1:0]   pmData,
   output logic [PA_W-1:0]      pmAddr,
   output logic [6:0]           periphAddr,
   output logic [15:0]          periphWrData,
   output logic                 periphWr,
   output logic                 periphRd,
   input  wire logic [15:0]     periphRdData,
   input  wire logic [3:0]      wakeIn,
   input  wire logic [RA_W-1:0] regAddr,
   input  wire logic [RD_W-1:0] regWdata,
   input  wire logic            regWr,
   input  wire logic            regRd,
   output logic [RD_W-1:0]      regRdata,
   output logic                 intEnable,
   output logic                 intState,
   output logic [1:0]           cpuMode
);
   localparam int SP_W = $clog2(STK_DEPTH);

   // ---------------------------------------------------------
   // state
   // ---------------------------------------------------------
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [PA_W-1:0] pmAddr;
      logic [15:0]     ar;
      logic [3:0]      wr;
      logic [15:0]     dbf;
      logic            master_interrupt_enable_flag;
      logic            intState;
      logic            savedInt;
      ccd_mode_t       mode;
      logic [3:0]      relCond;
      logic            skip;
      logic            getPend;
      logic [3:0]      wakeSw;
      logic [6:0]      periphAddr;
      logic [15:0]     periphWrData;
      logic            periphWr;
      logic            periphRd;
      logic [RD_W-1:0] regRdata;
   } ccd_state_t;

   ccd_state_t st;
   ccd_state_t next_st;

   ccd_core_if #(.SP_W(SP_W), .RFA_W(7)) bus ();

   ccd_addr_stack #(.DEPTH(STK_DEPTH)) u_stack (
      .clk  (clk),
      .nrst (nrst),
      .bus  (bus)
   );

   ccd_reg_file #(.AW(7), .DW(4)) u_rf (
      .clk  (clk),
      .nrst (nrst),
      .bus  (bus)
   );

   // ---------------------------------------------------------
   // decode
   // ---------------------------------------------------------
   function automatic logic isSys(input logic [IW-1:0] i, input logic [2:0] g,
                                  input logic [3:0] s);
      isSys = i[OP_MSB:OP_LSB] == OP_SYS && i[GRP_MSB:GRP_LSB] == g
              && i[SUB_MSB:SUB_LSB] == s && i[OPND_MSB:OPND_LSB] == OPND_ZERO;
   endfunction

   function automatic logic isSub(input logic [IW-1:0] i, input logic [3:0] s);
      isSub = i[OP_MSB:OP_LSB] == OP_SYS && i[SUB_MSB:SUB_LSB] == s;
   endfunction

   logic [4:0]      op;
   logic [2:0]      fGrp;
   logic [3:0]      fOpnd;
   logic [PC_W-1:0] fAddr;
   logic [PC_W-1:0] pcInc;
   logic [PC_W-1:0] topPc;
   logic [15:0]     dbfCur;
   logic [3:0]      wake;
   logic            exec;

   assign op     = pmData[OP_MSB:OP_LSB];
   assign fGrp   = pmData[GRP_MSB:GRP_LSB];
   assign fOpnd  = pmData[OPND_MSB:OPND_LSB];
   assign fAddr  = PC_W'(pmData[ADDR_MSB:0]);
   assign pcInc  = st.pc + 1'b1;
   assign topPc  = bus.stkTop[PC_W-1:0];
   // a get result still in flight is forwarded so a put right after sees it
   assign dbfCur = st.getPend ? periphRdData : st.dbf;
   assign wake   = wakeIn | st.wakeSw;
   assign exec   = st.mode == MODE_RUN && !st.skip;

   function automatic logic [RD_W-1:0] readReg(input logic [RA_W-1:0] a,
                                               input ccd_state_t s,
                                               input logic [SP_W-1:0] sp);
      case (a)
         REG_STATUS:  readReg = RD_W'({s.relCond, sp, s.getPend, s.skip, s.savedInt,
                                       s.intState, s.master_interrupt_enable_flag, s.mode});
         REG_PC:      readReg = RD_W'(s.pc);
         REG_AR:      readReg = s.ar;
         REG_WR:      readReg = RD_W'(s.wr);
         REG_DBF:     readReg = s.dbf;
         REG_INTSAVE: readReg = RD_W'(s.savedInt);
         default:     readReg = '0;
      endcase
   endfunction

   // ---------------------------------------------------------
   // execution
   // ---------------------------------------------------------
   always_comb begin
      next_st          = st;
      next_st.periphWr = 1'b0;
      next_st.periphRd = 1'b0;
      next_st.getPend  = 1'b0;
      next_st.wakeSw   = '0;
      next_st.regRdata = '0;
      bus.stkPush      = 1'b0;
      bus.stkPop       = 1'b0;
      bus.stkWdata     = st.ar;
      bus.rfWe         = 1'b0;
      bus.rfAddr       = {fGrp, fOpnd}; // RL20
      bus.rfWdata      = st.wr;
      next_st.dbf      = dbfCur; // RL6
      case (st.mode)
         MODE_RUN: begin
            // RL21
            next_st.pc     = pcInc;
            next_st.pmAddr = PA_W'(pcInc);
            // RL22
            next_st.skip   = 1'b0;
            if (exec) begin
               if (op == OP_BR) begin
                  next_st.pc     = fAddr; // RL8
                  next_st.pmAddr = PA_W'(fAddr);
               end else if (op == OP_CALL) begin
                  bus.stkPush    = 1'b1; // RL9
                  bus.stkWdata   = PA_W'(pcInc);
                  next_st.pc     = fAddr;
                  next_st.pmAddr = PA_W'(fAddr);
               end else if (isSys(pmData, GRP_PLAIN, SUB_TBL)) begin
                  // the return address rides on the address stack
                  bus.stkPush    = 1'b1; // RL1
                  bus.stkWdata   = PA_W'(pcInc);
                  next_st.pc     = st.pc;
                  next_st.pmAddr = st.ar;
                  next_st.mode   = MODE_TBL;
               end else if (isSys(pmData, GRP_PLAIN, SUB_PUSH)) begin
                  bus.stkPush = 1'b1; // RL2
               end else if (isSys(pmData, GRP_PLAIN, SUB_POP)) begin
                  bus.stkPop = 1'b1; // RL3
                  next_st.ar = bus.stkTop;
               end else if (isSub(pmData, SUB_REGFILE_READ_INSTR)) begin
                  next_st.wr = bus.rfRdata; // RL4
               end else if (isSub(pmData, SUB_REGFILE_WRITE_INSTR)) begin
                  bus.rfWe = 1'b1; // RL5
               end else if (isSub(pmData, SUB_GET)) begin
                  next_st.periphRd   = 1'b1; // RL6
                  next_st.periphAddr = {fGrp, fOpnd};
                  next_st.getPend    = 1'b1;
               end else if (isSub(pmData, SUB_PUT)) begin
                  next_st.periphWr     = 1'b1; // RL7
                  next_st.periphAddr   = {fGrp, fOpnd};
                  next_st.periphWrData = dbfCur;
               end else if (isSys(pmData, GRP_PLAIN, SUB_BRAR)) begin
                  next_st.pc     = st.ar[PC_W-1:0]; // RL8
                  next_st.pmAddr = PA_W'(st.ar[PC_W-1:0]);
               end else if (isSys(pmData, GRP_PLAIN, SUB_CALLAR)) begin
                  bus.stkPush    = 1'b1; // RL10
                  bus.stkWdata   = PA_W'(pcInc);
                  next_st.pc     = st.ar[PC_W-1:0];
                  next_st.pmAddr = PA_W'(st.ar[PC_W-1:0]);
               end else if (isSub(pmData, SUB_RET) && fOpnd == OPND_ZERO
                            && (fGrp == GRP_PLAIN || fGrp == GRP_ALT
                                || fGrp == GRP_INT)) begin
                  bus.stkPop     = 1'b1; // RL11
                  next_st.pc     = topPc;
                  next_st.pmAddr = PA_W'(topPc);
                  if (fGrp == GRP_ALT) begin
                     next_st.skip = 1'b1; // RL12
                  end
                  if (fGrp == GRP_INT) begin
                     next_st.intState = st.savedInt; // RL13
                  end
               end else if (isSys(pmData, GRP_PLAIN, SUB_MISC)) begin
                  next_st.master_interrupt_enable_flag = 1'b1; // RL14
               end else if (isSys(pmData, GRP_ALT, SUB_MISC)) begin
                  next_st.master_interrupt_enable_flag = 1'b0; // RL15
               end else if (isSub(pmData, SUB_MISC) && fGrp == GRP_STOP) begin
                  next_st.mode    = MODE_STOP; // RL16
                  next_st.relCond = fOpnd; // RL19
               end else if (isSub(pmData, SUB_MISC) && fGrp == GRP_HALT) begin
                  next_st.mode    = MODE_HALT; // RL17
                  next_st.relCond = fOpnd;
               end
               // undefined codes and the no-operation only advance the counter
               // RL18
            end
         end
         MODE_TBL: begin
            // second cycle: fetched word goes to the buffer, return pops
            next_st.dbf    = pmData; // RL1
            bus.stkPop     = 1'b1;
            next_st.pc     = topPc;
            next_st.pmAddr = PA_W'(topPc);
            next_st.mode   = MODE_RUN;
         end
         MODE_HALT, MODE_STOP: begin
            // a zero condition field can only be left by reset
            if (|(wake & st.relCond)) begin
               next_st.mode = MODE_RUN;
            end
         end
         default: begin
            next_st.mode = MODE_RUN;
         end
      endcase
      // software access last, so a register write wins over the instruction
      if (regWr) begin
         case (regAddr)
            REG_AR:      next_st.ar       = regWdata;
            REG_WR:      next_st.wr       = regWdata[3:0];
            REG_DBF:     next_st.dbf      = regWdata;
            REG_WAKE:    next_st.wakeSw   = regWdata[3:0];
            REG_INTSAVE: next_st.savedInt = regWdata[0];
            default:     next_st.savedInt = st.savedInt;
         endcase
      end
      if (regRd) begin
         next_st.regRdata = readReg(regAddr, st, bus.stkPtr);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st          <= '0;
         st.ar       <= RST_AR;
         st.wr       <= RST_WR;
         st.dbf      <= RST_DBF;
         st.mode     <= MODE_RUN;
      end else begin
         st <= next_st;
      end
   end

   assign pmAddr       = st.pmAddr;
   assign periphAddr   = st.periphAddr;
   assign periphWrData = st.periphWrData;
   assign periphWr     = st.periphWr;
   assign periphRd     = st.periphRd;
   assign regRdata     = st.regRdata;
   assign intEnable    = st.master_interrupt_enable_flag;
   assign intState     = st.intState;
   assign cpuMode      = st.mode;

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_tbl_two;
      exec && isSys(pmData, GRP_PLAIN, SUB_TBL) |=>
         st.mode == MODE_TBL ##1 st.mode == MODE_RUN && pmAddr == $past(pmAddr, 2) + 1'b1;
   endproperty
   a_tbl_two: assert property (p_tbl_two) // RL1
      else $error("table read did not take two cycles");

   property p_push;
      exec && isSys(pmData, GRP_PLAIN, SUB_PUSH) |=>
         bus.stkPtr == $past(bus.stkPtr) - 1'b1 && bus.stkTop == $past(st.ar);
   endproperty
   a_push: assert property (p_push) // RL2
      else $error("push did not store the address pointer");

   property p_pop;
      exec && !regWr && isSys(pmData, GRP_PLAIN, SUB_POP) |=>
         st.ar == $past(bus.stkTop) && bus.stkPtr == $past(bus.stkPtr) + 1'b1;
   endproperty
   a_pop: assert property (p_pop) // RL3
      else $error("pop did not restore the address pointer");

   property p_regfile_read_instr;
      exec && !regWr && isSub(pmData, SUB_REGFILE_READ_INSTR) |=> st.wr == $past(bus.rfRdata);
   endproperty
   a_regfile_read_instr: assert property (p_regfile_read_instr) // RL4
      else $error("regfile read missed the window");

   property p_get;
      exec && isSub(pmData, SUB_GET) |=> periphRd && periphAddr == $past(pmData[10:4]
         & 7'h70 | pmData[3:0]);
   endproperty
   a_get: assert property (p_get) // RL6
      else $error("peripheral read not issued");

   property p_put;
      exec && isSub(pmData, SUB_PUT) |=> periphWr && periphWrData == $past(dbfCur);
   endproperty
   a_put: assert property (p_put) // RL7
      else $error("peripheral write lost the data buffer");

   property p_call;
      exec && op == OP_CALL |=>
         pmAddr == PA_W'($past(fAddr)) && bus.stkTop == PA_W'($past(pcInc));
   endproperty
   a_call: assert property (p_call) // RL9
      else $error("call did not save the return address");

   property p_skip;
      exec && isSys(pmData, GRP_ALT, SUB_RET) |=>
         st.skip ##1 !st.skip && !periphWr && !periphRd && pmAddr == $past(pmAddr) + 1'b1;
   endproperty
   a_skip: assert property (p_skip) // RL12
      else $error("return and skip did not drop one instruction");

   property p_master_interrupt_enable_flag;
      exec && isSys(pmData, GRP_ALT, SUB_MISC) |=> !intEnable;
   endproperty
   a_master_interrupt_enable_flag: assert property (p_master_interrupt_enable_flag) // RL15
      else $error("disable left interrupts on");

   property p_stop;
      exec && isSub(pmData, SUB_MISC) && fGrp == GRP_STOP && fOpnd != OPND_ZERO
         && wakeIn == OPND_ZERO |=> cpuMode == MODE_STOP && st.relCond == $past(fOpnd);
   endproperty
   a_stop: assert property (p_stop) // RL19
      else $error("stop conditions not captured");

   property p_nop;
      exec && !regWr && isSys(pmData, GRP_INT, SUB_MISC) |=>
         $stable(st.ar) && $stable(st.wr) && $stable(intEnable) && !periphWr;
   endproperty
   a_nop: assert property (p_nop) // RL18
      else $error("no-operation changed state");
endmodule

/* File: logic/ccd_core_if.sv */
`timescale 1ns/1ps
interface ccd_core_if #(parameter int SP_W = 3, parameter int RFA_W = 7);
   logic             stkPush;
   logic             stkPop;
   logic [15:0]      stkWdata;
   logic [15:0]      stkTop;
   logic [SP_W-1:0]  stkPtr;
   logic             rfWe;
   logic [RFA_W-1:0] rfAddr;
   logic [3:0]       rfWdata;
   logic [3:0]       rfRdata;
   modport ctl (output stkPush, stkPop, stkWdata, rfWe, rfAddr, rfWdata,
                input  stkTop, stkPtr, rfRdata);
   modport stk (input  stkPush, stkPop, stkWdata, output stkTop, stkPtr);
   modport rf  (input  rfWe, rfAddr, rfWdata, output rfRdata);
endinterface

/* File: logic/ccd_pkg.sv */
// ------------------------------------------------------------
// Overview of operation
// RL1 - table read move spends two cycles
// RL2 - push: stack pointer down, store address pointer
// RL3 - pop: load address pointer, stack pointer up
// RL4 - regfile read copies location into window
// RL5 - regfile write stores window into location
// RL6 - peripheral read loads data buffer
// RL7 - peripheral write sends data buffer out
// RL8 - branch loads counter from field or pointer
// RL9 - direct call pushes counter, jumps to field
// RL10 - indirect call pushes counter, jumps to pointer
// RL11 - return restores counter, stack pointer up
// RL12 - return and skip drops first instruction
// RL13 - interrupt return also restores interrupt state
// RL14 - enable instruction sets master interrupt flag
// RL15 - disable instruction clears master interrupt flag
// RL16 - stop instruction enters stop with conditions
// RL17 - halt instruction enters halt with conditions
// RL18 - no-operation changes nothing but the counter
// RL19 - stop operand selects stop release conditions
// RL20 - regfile address is row high, column low
// RL21 - all other instructions finish in one cycle
// RL22 - skipped instruction runs as a no-operation
// ------------------------------------------------------------
package ccd_pkg;
   // ---------------------------------------------------------
   // instruction fields
   // ---------------------------------------------------------
   localparam int IW       = 16;
   localparam int OP_MSB   = 15;
   localparam int OP_LSB   = 11;
   localparam int GRP_MSB  = 10;
   localparam int GRP_LSB  = 8;
   localparam int SUB_MSB  = 7;
   localparam int SUB_LSB  = 4;
   localparam int OPND_MSB = 3;
   localparam int OPND_LSB = 0;
   localparam int ADDR_MSB = 10;
   localparam int PA_W     = 16;
   localparam int RA_W     = 8;
   localparam int RD_W     = 16;

   localparam logic [4:0] OP_SYS     = 5'h07;
   localparam logic [4:0] OP_BR      = 5'h0C;
   localparam logic [4:0] OP_CALL    = 5'h1C;
   localparam logic [3:0] SUB_TBL    = 4'h1;
   localparam logic [3:0] SUB_REGFILE_WRITE_INSTR   = 4'h2;
   localparam logic [3:0] SUB_REGFILE_READ_INSTR   = 4'h3;
   localparam logic [3:0] SUB_BRAR   = 4'h4;
   localparam logic [3:0] SUB_CALLAR = 4'h5;
   localparam logic [3:0] SUB_PUT    = 4'hA;
   localparam logic [3:0] SUB_GET    = 4'hB;
   localparam logic [3:0] SUB_POP    = 4'hC;
   localparam logic [3:0] SUB_PUSH   = 4'hD;
   localparam logic [3:0] SUB_RET    = 4'hE;
   localparam logic [3:0] SUB_MISC   = 4'hF;
   localparam logic [2:0] GRP_PLAIN  = 3'h0;
   localparam logic [2:0] GRP_ALT    = 3'h1;
   localparam logic [2:0] GRP_STOP   = 3'h2;
   localparam logic [2:0] GRP_HALT   = 3'h3;
   localparam logic [2:0] GRP_INT    = 3'h4;
   localparam logic [3:0] OPND_ZERO  = 4'h0;

   // ---------------------------------------------------------
   // register map and reset values
   // ---------------------------------------------------------
   localparam logic [7:0]  REG_STATUS  = 8'h00;
   localparam logic [7:0]  REG_PC      = 8'h01;
   localparam logic [7:0]  REG_AR      = 8'h02;
   localparam logic [7:0]  REG_WR      = 8'h03;
   localparam logic [7:0]  REG_DBF     = 8'h04;
   localparam logic [7:0]  REG_WAKE    = 8'h05;
   localparam logic [7:0]  REG_INTSAVE = 8'h06;
   localparam logic [15:0] RST_AR      = 16'h0000;
   localparam logic [3:0]  RST_WR      = 4'h0;
   localparam logic [15:0] RST_DBF     = 16'h0000;

   typedef enum logic [1:0] {
      MODE_RUN  = 2'b00,
      MODE_TBL  = 2'b01,
      MODE_HALT = 2'b10,
      MODE_STOP = 2'b11
   } ccd_mode_t;
endpackage

/* File: logic/ccd_reg_file.sv */
`timescale 1ns/1ps
module ccd_reg_file
#(
   parameter int AW = 7,
   parameter int DW = 4
) (
   input wire logic clk,
   input wire logic nrst,
   ccd_core_if.rf   bus
);
   typedef struct packed {
      logic [(2**AW)-1:0][DW-1:0] ent;
   } ccd_rf_t;

   ccd_rf_t st;
   ccd_rf_t next_st;

   always_comb begin
      next_st = st;
      if (bus.rfWe) begin
         next_st.ent[bus.rfAddr] = bus.rfWdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // read is combinational so a read instruction completes in its own cycle
   assign bus.rfRdata = st.ent[bus.rfAddr];
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb
   import ccd_pkg::*;
;
   // ---------------------------------------------------------
   // signals
   // ---------------------------------------------------------
   logic              clk;
   logic              nrst;
   logic [IW-1:0]     pmData;
   logic [PA_W-1:0]   pmAddr;
   logic [6:0]        periphAddr;
   logic [15:0]       periphWrData;
   logic              periphWr;
   logic              periphRd;
   logic [15:0]       periphRdData;
   logic [3:0]        wakeIn;
   logic [RA_W-1:0]   regAddr;
   logic [RD_W-1:0]   regWdata;
   logic              regWr;
   logic              regRd;
   logic [RD_W-1:0]   regRdata;
   logic              intEnable;
   logic              intState;
   logic [1:0]        cpuMode;
   logic [IW-1:0]     mem [0:255];
   logic [255:0]      visited;
   logic              sawIe;
   logic [6:0]        rdAddr;
   logic [6:0]        wrAddr;
   logic [15:0]       wrData;
   logic [15:0]       d;
   int                err_count;
   int                n_tests;
   int                tblCycles;

   ccd_control_top #(.PC_W(11), .STK_DEPTH(8)) u_dut (
      .clk(clk), .nrst(nrst), .pmData(pmData), .pmAddr(pmAddr),
      .periphAddr(periphAddr), .periphWrData(periphWrData), .periphWr(periphWr),
      .periphRd(periphRd), .periphRdData(periphRdData), .wakeIn(wakeIn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .intEnable(intEnable), .intState(intState),
      .cpuMode(cpuMode));

   // async-read program memory, as the core expects
   assign pmData = mem[pmAddr[7:0]];

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   function automatic logic [15:0] sys(input logic [2:0] g, input logic [3:0] s,
                                       input logic [3:0] o);
      return {OP_SYS, g, s, o};
   endfunction

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask

   // bounded wait: a hang ends the run as a mismatch
   task automatic wait_mode(input logic [1:0] m);
      for (int i = 0; i < 300; i++) begin
         @(posedge clk);
         #1;
         if (cpuMode === m) return;
      end
      $display("FAIL cpuMode expected %h seen %h", m, cpuMode);
      err_count++;
      end_of_test();
   endtask

   task automatic wake;
      @(posedge clk);
      wakeIn <= 4'h1;
      @(posedge clk);
      wakeIn <= 4'h0;
      wait_mode(MODE_RUN);
   endtask

   task automatic chk_sp(input logic [2:0] e);
      rd(REG_STATUS);
      chk("stack pointer", {13'h0000, e}, {13'h0000, d[9:7]});
   endtask

   // ---------------------------------------------------------
   // passive monitor of the peripheral side and of execution
   // ---------------------------------------------------------
   always @(posedge clk) begin
      if (nrst) begin
         if (cpuMode === MODE_RUN) visited[pmAddr[7:0]] <= 1'b1;
         if (cpuMode === MODE_TBL) tblCycles++;
         if (periphRd === 1'b1) rdAddr <= periphAddr;
         if (periphWr === 1'b1) begin
            wrAddr <= periphAddr;
            wrData <= periphWrData;
         end
         if (intEnable === 1'b1) sawIe <= 1'b1;
      end
   end

   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial begin
      nrst = 1'b0; wakeIn = 4'h0; regAddr = 8'h00; regWdata = 16'h0000;
      regWr = 1'b0; regRd = 1'b0; periphRdData = 16'h5A3C;
      err_count = 0; n_tests = 0; tblCycles = 0; visited = '0; sawIe = 1'b0;
      // unused words park in a stop that never releases, so a stray jump hangs
      for (int i = 0; i < 256; i++) mem[i] = sys(GRP_STOP, SUB_MISC, 4'h0);
      mem[8'h00] = sys(GRP_HALT, SUB_MISC, 4'h1);
      mem[8'h01] = sys(GRP_PLAIN, SUB_PUSH, 4'h0);
      mem[8'h02] = {OP_SYS, 3'h5, SUB_REGFILE_WRITE_INSTR, 4'h3};
      mem[8'h03] = sys(GRP_HALT, SUB_MISC, 4'h1);
      mem[8'h04] = sys(GRP_PLAIN, SUB_POP, 4'h0);
      mem[8'h05] = {OP_SYS, 3'h5, SUB_REGFILE_READ_INSTR, 4'h3};
      mem[8'h06] = sys(GRP_HALT, SUB_MISC, 4'h1);
      mem[8'h07] = sys(GRP_PLAIN, SUB_BRAR, 4'h0);
      mem[8'h20] = {OP_CALL, 11'h040};
      mem[8'h40] = sys(GRP_HALT, SUB_MISC, 4'h1);
      mem[8'h41] = sys(GRP_ALT, SUB_RET, 4'h0);
      mem[8'h21] = sys(GRP_PLAIN, SUB_MISC, 4'h0);
      mem[8'h22] = sys(GRP_INT, SUB_MISC, 4'h0);
      mem[8'h23] = sys(GRP_HALT, SUB_MISC, 4'h1);
      mem[8'h24] = sys(GRP_PLAIN, SUB_MISC, 4'h0);
      mem[8'h25] = sys(GRP_PLAIN, SUB_CALLAR, 4'h0);
      mem[8'h60] = sys(GRP_ALT, SUB_MISC, 4'h0);
      mem[8'h61] = sys(GRP_INT, SUB_RET, 4'h0);
      mem[8'h26] = sys(GRP_HALT, SUB_MISC, 4'h1);
      mem[8'h27] = {OP_SYS, 3'h2, SUB_GET, 4'h5};
      mem[8'h28] = {OP_SYS, 3'h6, SUB_PUT, 4'h1};
      mem[8'h29] = sys(GRP_PLAIN, SUB_TBL, 4'h0);
      mem[8'h2A] = sys(GRP_STOP, SUB_MISC, 4'h2);
      mem[8'h2B] = {OP_CALL, 11'h050};
      mem[8'h50] = sys(GRP_PLAIN, SUB_RET, 4'h0);
      mem[8'h2C] = {OP_BR, 11'h030};
      mem[8'h30] = sys(GRP_HALT, SUB_MISC, 4'h1);
      mem[8'h70] = 16'hBEEF;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;

      wait_mode(MODE_HALT);
      wr(REG_AR, 16'h0020);
      wr(REG_WR, 16'h0009);
      wr(REG_DBF, 16'hA5C3);
      wake();
      wait_mode(MODE_HALT);
      chk_sp(3'h7);
      wr(REG_AR, 16'h0000);
      wr(REG_WR, 16'h0000);
      wake();
      wait_mode(MODE_HALT);
      rd(REG_AR);   chk("pointer after pop", 16'h0020, d);
      rd(REG_WR);   chk("window after regfile_read_instr", 16'h0009, d);
      chk_sp(3'h0);
      rd(8'h7F);    chk("unmapped read", 16'h0000, d);
      $display("test stack and regfile done");
      wake();

      wait_mode(MODE_HALT);
      chk("branch via pointer", 16'h0001, {15'h0000, visited[8'h20]});
      chk("fall through", 16'h0000, {15'h0000, visited[8'h08]});
      chk("call target", 16'h0001, {15'h0000, visited[8'h40]});
      chk_sp(3'h7);
      wake();
      wait_mode(MODE_HALT);
      chk("skipped enable", 16'h0000, {15'h0000, sawIe});
      chk_sp(3'h0);
      wr(REG_AR, 16'h0060);
      wr(REG_INTSAVE, 16'h0001);
      $display("test branch call skip done");
      wake();

      wait_mode(MODE_HALT);
      chk("enable seen", 16'h0001, {15'h0000, sawIe});
      chk("enable cleared", 16'h0000, {15'h0000, intEnable});
      chk("restored state", 16'h0001, {15'h0000, intState});
      chk("indirect call", 16'h0001, {15'h0000, visited[8'h60]});
      chk_sp(3'h0);
      wr(REG_AR, 16'h0070);
      $display("test interrupt flags done");
      wake();

      wait_mode(MODE_STOP);
      chk("get address", 16'h0025, {9'h000, rdAddr});
      chk("put data", 16'h5A3C, wrData);
      chk("put address", 16'h0061, {9'h000, wrAddr});
      rd(REG_DBF);  chk("table word", 16'hBEEF, d);
      chk("table cycles", 16'h0001, tblCycles[15:0]);
      chk_sp(3'h0);
      // a wake event outside the condition field must not release the stop
      @(posedge clk);
      wakeIn <= 4'h1;
      repeat (3) @(posedge clk);
      #1 chk("stop held", {14'h0000, MODE_STOP}, {14'h0000, cpuMode});
      @(posedge clk);
      wakeIn <= 4'h0;
      // software wake event through the register port releases the stop
      wr(REG_WAKE, 16'h0002);
      wait_mode(MODE_HALT);
      chk("plain return", 16'h0001, {15'h0000, visited[8'h50]});
      chk("direct branch", 16'h0001, {15'h0000, visited[8'h2C]});
      chk_sp(3'h0);
      rd(REG_WR);   chk("window kept", 16'h0009, d);
      $display("test peripheral table stop done");
      end_of_test();
   end
endmodule
